// file: hw/serial_port_pkg.sv
// Function
// - Received bits pass shift register, then buffer register, then data register for reading.
// - While data register is unread, nothing moves from buffer to data, and nothing moves from shift to buffer once buffer is full.
// - When blocked, overrun flag sets and new serial data overwrites the shift register.
// - Overrun flag raises no interrupt; software polls it.
// - Early receive frame sync aborts reception and restarts with the new frame.
// - Early receive frame sync sets the receive sync error flag.
// - Early transmit frame sync aborts the current word and restarts transmission.
// - Early transmit frame sync sets the transmit sync error flag.
// - A word written to the transmit data register is copied into the shift register.
// - A transmit frame sync shifts the shift register out on the data pin.
// - Without a new word, each frame sync resends the previous word.
// - Underflow drives the active low transmit empty flag to 0, no interrupt.
package serial_port_pkg;
   localparam int WORD_W  = 16;
   localparam int CNT_W   = 5;
   localparam int FIFO_D  = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

   typedef struct packed {
      logic              valid;
      logic [WORD_W-1:0] data;
   } word_t;

   typedef struct packed {
      logic rx_overrun_flag;
      logic rx_sync_error_flag;
      logic tx_sync_error_flag;
      logic tx_empty_n_flag;
   } status_t;
endpackage : serial_port_pkg

// file: hw/serial_port.sv
`timescale 1ns/1ps
// ----------------------------------------
// Word FIFO
// ----------------------------------------
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_valid,
   output logic                  o_ready,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic      [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } fifo_state_t;
   fifo_state_t st;
   fifo_state_t next_st;
   logic        push;
   logic        pop;

   assign o_ready = (st.cnt != (AW+1)'(DEPTH));
   assign o_valid = (st.cnt != '0);
   assign o_data  = st.mem[st.rd];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.mem[st.wr] = i_data;
         next_st.wr         = st.wr + 1'b1;
      end
      if (pop)
         next_st.rd = st.rd + 1'b1;
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         st <= '0;
      else
         st <= next_st;
   end
endmodule : word_fifo

// ----------------------------------------
// Serial port core
// ----------------------------------------
module serial_port #(
   parameter int WORD_BITS = serial_port_pkg::WORD_W
) (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_rstn,
   input  wire logic                          i_link_clk,
   input  wire logic                          i_rx_fsync,
   input  wire logic                          i_rx_data,
   input  wire logic                          i_tx_fsync,
   output logic                               o_tx_data,
   output serial_port_pkg::word_t             o_rx_word,
   input  wire logic                          i_rx_read,
   input  wire serial_port_pkg::word_t        i_tx_word,
   output logic                               o_tx_ready,
   input  wire logic                          i_clr_rx_sync_err,
   input  wire logic                          i_clr_tx_sync_err,
   output serial_port_pkg::status_t           o_status
);
   import serial_port_pkg::*;

   // ----------------------------------------
   // Link domain state
   // ----------------------------------------
   typedef struct packed {
      logic [1:0]        rx_fs_pin;
      logic [1:0]        rx_d_pin;
      logic [1:0]        tx_fs_pin;
      logic [WORD_W-1:0] rx_shift_reg;
      logic [CNT_W-1:0]  rx_cnt;
      logic              rx_busy;
      logic [WORD_W-1:0] rx_hold;
      logic              rx_tgl;
      logic              rx_err_tgl;
      logic [2:0]        rx_ack_s;
      logic              rx_pend;
      logic [WORD_W-1:0] tx_shift_reg;
      logic [CNT_W-1:0]  tx_cnt;
      logic              tx_busy;
      logic              tx_err_tgl;
      logic              tx_fs_tgl;
      logic              out_bit;
   } link_state_t;

   // ----------------------------------------
   // System domain state
   // ----------------------------------------
   typedef struct packed {
      logic [WORD_W-1:0] rx_buffer_reg;
      logic              buf_full;
      logic [WORD_W-1:0] rx_data_reg;
      logic              drr_full;
      logic [2:0]        rx_tgl_s;
      logic [2:0]        rx_err_s;
      logic [2:0]        tx_err_s;
      logic [2:0]        tx_fs_s;
      logic              rx_ack;
      logic [WORD_W-1:0] tx_data_reg;
      logic              tx_new;
      status_t           status;
   } sys_state_t;

   link_state_t ls;
   link_state_t next_ls;
   sys_state_t  ss;
   sys_state_t  next_ss;
   word_t       fifo_out;
   logic        fifo_ready;
   logic        fifo_pop;

   // Transmit words queue ahead of the data register so a burst of writes is not lost
   word_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_D)
   ) u_tx_fifo (
      .i_clk   (i_sys_clk),
      .i_rstn  (i_rstn),
      .i_valid (i_tx_word.valid),
      .o_ready (fifo_ready),
      .i_data  (i_tx_word.data),
      .o_valid (fifo_out.valid),
      .i_ready (fifo_pop),
      .o_data  (fifo_out.data)
   );
   assign o_tx_ready = fifo_ready;
   // Data register takes a queued word only once a frame sync has loaded the last one into the link shift register
   // Limitation: a word loaded within a few cycles of a frame sync may race it
   assign fifo_pop   = fifo_out.valid && !ss.tx_new;

   // ----------------------------------------
   // Link domain next state
   // ----------------------------------------
   always_comb
   begin
      next_ls = ls;
      // Pins come from outside, so two flops guard against metastability
      next_ls.rx_fs_pin = {ls.rx_fs_pin[0], i_rx_fsync};
      next_ls.rx_d_pin  = {ls.rx_d_pin[0], i_rx_data};
      next_ls.tx_fs_pin = {ls.tx_fs_pin[0], i_tx_fsync};
      next_ls.rx_ack_s  = {ls.rx_ack_s[1:0], ss.rx_ack};
      // Handshake return frees the hold register for the next word
      if (ls.rx_ack_s[2] != ls.rx_ack_s[1])
         next_ls.rx_pend = 1'b0;
      if (ls.rx_fs_pin[1])
      begin
         if (ls.rx_busy)
            next_ls.rx_err_tgl = ~ls.rx_err_tgl;
         next_ls.rx_busy      = 1'b1;
         next_ls.rx_cnt       = CNT_W'(WORD_BITS - 1);
         next_ls.rx_shift_reg = {{(WORD_W-1){1'b0}}, ls.rx_d_pin[1]};
      end
      else if (ls.rx_busy)
      begin
         // Shift register always takes new bits, even while blocked downstream
         next_ls.rx_shift_reg = {ls.rx_shift_reg[WORD_W-2:0], ls.rx_d_pin[1]};
         next_ls.rx_cnt       = ls.rx_cnt - CNT_ONE;
         if (ls.rx_cnt == CNT_ONE)
         begin
            next_ls.rx_busy = 1'b0;
            if (!ls.rx_pend)
            begin
               next_ls.rx_hold = {ls.rx_shift_reg[WORD_W-2:0], ls.rx_d_pin[1]};
               next_ls.rx_tgl  = ~ls.rx_tgl;
               next_ls.rx_pend = 1'b1;
            end
         end
      end
      if (ls.tx_fs_pin[1])
      begin
         if (ls.tx_busy)
            next_ls.tx_err_tgl = ~ls.tx_err_tgl;
         next_ls.tx_fs_tgl = ~ls.tx_fs_tgl;
         next_ls.tx_busy   = 1'b1;
         next_ls.tx_cnt    = CNT_W'(WORD_BITS - 1);
         // Data register is stable whenever the new flag is seen set
         next_ls.tx_shift_reg = {ss.tx_data_reg[WORD_W-2:0], 1'b0};
         next_ls.out_bit      = ss.tx_data_reg[WORD_W-1];
      end
      else if (ls.tx_busy)
      begin
         next_ls.out_bit      = ls.tx_shift_reg[WORD_W-1];
         next_ls.tx_shift_reg = {ls.tx_shift_reg[WORD_W-2:0], 1'b0};
         next_ls.tx_cnt       = ls.tx_cnt - CNT_ONE;
         if (ls.tx_cnt == CNT_ONE)
            next_ls.tx_busy = 1'b0;
      end
   end

   always_ff @(posedge i_link_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         ls <= '0;
      else
         ls <= next_ls;
   end

   assign o_tx_data = ls.out_bit;

   // ----------------------------------------
   // System domain next state
   // ----------------------------------------
   always_comb
   begin
      next_ss = ss;
      next_ss.rx_tgl_s = {ss.rx_tgl_s[1:0], ls.rx_tgl};
      next_ss.rx_err_s = {ss.rx_err_s[1:0], ls.rx_err_tgl};
      next_ss.tx_err_s = {ss.tx_err_s[1:0], ls.tx_err_tgl};
      next_ss.tx_fs_s  = {ss.tx_fs_s[1:0], ls.tx_fs_tgl};
      // Reading frees the data register, so the buffered word moves up
      if (i_rx_read && ss.drr_full)
      begin
         next_ss.drr_full               = 1'b0;
         next_ss.status.rx_overrun_flag = 1'b0;
      end
      if (ss.buf_full && !next_ss.drr_full)
      begin
         next_ss.rx_data_reg = ss.rx_buffer_reg;
         next_ss.drr_full    = 1'b1;
         next_ss.buf_full    = 1'b0;
         next_ss.rx_ack      = ~ss.rx_ack;
      end
      if (ss.rx_tgl_s[2] != ss.rx_tgl_s[1])
      begin
         next_ss.rx_buffer_reg = ls.rx_hold;
         next_ss.buf_full      = 1'b1;
      end
      // Ack stays held while buffer is full, blocking the shift-to-buffer move
      // Judged on the next state so a read that frees the path can clear it
      if (next_ss.buf_full && next_ss.drr_full)
         next_ss.status.rx_overrun_flag = 1'b1;
      if (i_clr_rx_sync_err)
         next_ss.status.rx_sync_error_flag = 1'b0;
      if (ss.rx_err_s[2] != ss.rx_err_s[1])
         next_ss.status.rx_sync_error_flag = 1'b1;
      if (i_clr_tx_sync_err)
         next_ss.status.tx_sync_error_flag = 1'b0;
      if (ss.tx_err_s[2] != ss.tx_err_s[1])
         next_ss.status.tx_sync_error_flag = 1'b1;
      if (fifo_pop)
      begin
         next_ss.tx_data_reg = fifo_out.data;
         next_ss.tx_new      = 1'b1;
         next_ss.status.tx_empty_n_flag = 1'b1;
      end
      if (ss.tx_fs_s[2] != ss.tx_fs_s[1])
      begin
         if (ss.tx_new)
            next_ss.tx_new = 1'b0;
         else if (!fifo_pop)
            next_ss.status.tx_empty_n_flag = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ss                        <= '0;
         ss.status.tx_empty_n_flag <= 1'b1;
      end
      else
         ss <= next_ss;
   end

   assign o_rx_word.valid = ss.drr_full;
   assign o_rx_word.data  = ss.rx_data_reg;
   assign o_status        = ss.status;
endmodule : serial_port

// file: testbench/serial_port_asserts.sv
`timescale 1ns/1ps
// ---
// Checker
// ---
module serial_port_asserts (
   input wire logic                    i_sys_clk,
   input wire logic                    i_rstn,
   input wire serial_port_pkg::word_t  o_rx_word,
   input wire logic                    i_rx_read,
   input wire serial_port_pkg::word_t  i_tx_word,
   input wire logic                    o_tx_ready,
   input wire logic                    i_clr_rx_sync_err,
   input wire logic                    i_clr_tx_sync_err,
   input wire serial_port_pkg::status_t o_status
);
   import serial_port_pkg::*;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   chk_reset_vals: assert property ($rose(i_rstn) |-> o_status == 4'h1 && !o_rx_word.valid)
      else $error("status not at reset value");
   chk_rx_hold: assert property (o_rx_word.valid && !i_rx_read |=>
      o_rx_word.valid && $stable(o_rx_word.data)) else $error("unread word changed");
   chk_valid_drop: assert property ($fell(o_rx_word.valid) |-> $past(i_rx_read))
      else $error("word dropped without read");
   chk_ovr_rise: assert property ($rose(o_status.rx_overrun_flag) |-> o_rx_word.valid)
      else $error("overrun without full data");
   chk_ovr_stay: assert property (o_status.rx_overrun_flag && !i_rx_read |=>
      o_status.rx_overrun_flag) else $error("overrun flag lost");
   chk_ovr_clear: assert property (o_status.rx_overrun_flag && i_rx_read |->
      ##[1:4] !o_status.rx_overrun_flag) else $error("overrun not cleared");
   chk_rxsync_fall: assert property ($fell(o_status.rx_sync_error_flag) |->
      $past(i_clr_rx_sync_err)) else $error("rx sync flag fell alone");
   chk_txsync_fall: assert property ($fell(o_status.tx_sync_error_flag) |->
      $past(i_clr_tx_sync_err)) else $error("tx sync flag fell alone");
   chk_empty_set: assert property (i_tx_word.valid && o_tx_ready |->
      ##[1:8] o_status.tx_empty_n_flag) else $error("empty flag not set");
endmodule : serial_port_asserts

bind serial_port serial_port_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
   .o_rx_word(o_rx_word), .i_rx_read(i_rx_read), .i_tx_word(i_tx_word),
   .o_tx_ready(o_tx_ready), .i_clr_rx_sync_err(i_clr_rx_sync_err),
   .i_clr_tx_sync_err(i_clr_tx_sync_err), .o_status(o_status));

// file: testbench/serial_partner.sv
`timescale 1ns/1ps
// ---
// Far side serial device
// ---
module serial_partner (
   input  wire logic i_link_clk,
   input  wire logic i_tx_data,
   output logic      o_rx_fsync,
   output logic      o_rx_data,
   output logic      o_tx_fsync
);
   initial
   begin
      o_rx_fsync = 1'b0;
      o_rx_data  = 1'b0;
      o_tx_fsync = 1'b0;
   end
   // Fewer than 16 bits leaves a short frame; idle line shows the inverse of the last bit
   task automatic send_word(input logic [15:0] w, input int nbits);
      for (int k = 0; k < nbits; k++)
      begin
         @(posedge i_link_clk);
         o_rx_fsync <= (k == 0);
         o_rx_data  <= w[15-k];
      end
      @(posedge i_link_clk);
      o_rx_fsync <= 1'b0;
      o_rx_data  <= ~w[16-nbits];
   endtask : send_word
   task automatic take_word(input int nbits, output logic [15:0] w);
      w = 16'h0000;
      repeat (4) @(posedge i_link_clk);
      o_tx_fsync <= 1'b1;
      @(posedge i_link_clk);
      o_tx_fsync <= 1'b0;
      // Two pin flops delay the first bit by two link edges
      repeat (2) @(posedge i_link_clk);
      for (int k = 0; k < nbits; k++)
      begin
         #1 w = {w[14:0], i_tx_data};
         @(posedge i_link_clk);
      end
   endtask : take_word
endmodule : serial_partner

// file: testbench/test_buffered_serial_port_error_flags.sv
`timescale 1ns/1ps
module test_buffered_serial_port_error_flags;
   import serial_port_pkg::*;
   logic sys_clk, link_clk, rstn, rx_read, clr_rx, clr_tx, rx_fs, rx_d, tx_fs, tx_d, ok;
   word_t rx_word, tx_word;
   logic tx_ready;
   status_t status;
   logic [15:0] w, a, b, got, txq[$];
   int n_errors = 0;
   int comparisons = 0;
   int n;
   serial_port uut (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_link_clk(link_clk),
      .i_rx_fsync(rx_fs), .i_rx_data(rx_d), .i_tx_fsync(tx_fs), .o_tx_data(tx_d),
      .o_rx_word(rx_word), .i_rx_read(rx_read), .i_tx_word(tx_word), .o_tx_ready(tx_ready),
      .i_clr_rx_sync_err(clr_rx), .i_clr_tx_sync_err(clr_tx), .o_status(status));
   serial_partner p (.i_link_clk(link_clk), .i_tx_data(tx_d), .o_rx_fsync(rx_fs),
      .o_rx_data(rx_d), .o_tx_fsync(tx_fs));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #3;
      forever #6 link_clk = ~link_clk;
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test
   task automatic pause(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask : pause
   // Bounded wait keeps a dead receive path from hanging the run
   task automatic read_rx(input logic [15:0] exp);
      for (int t = 0; t < 200 && rx_word.valid !== 1'b1; t++)
         pause(1);
      check("rx word", rx_word.data, exp);
      @(posedge sys_clk) rx_read <= 1'b1;
      @(posedge sys_clk) rx_read <= 1'b0;
   endtask : read_rx
   initial
   begin
      #200000;
      n_errors++;
      end_of_test();
   end
   initial
   begin
      void'($urandom(59737));
      {rstn, rx_read, clr_rx, clr_tx} = 4'h0;
      tx_word = '0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      pause(1);
      check("status", {12'h000, status}, 16'h0001);
      for (int i = 0; i < 4; i++)
      begin
         w = 16'($urandom);
         p.send_word(w, 16);
         read_rx(w);
      end
      a = 16'($urandom);
      b = ~a;
      p.send_word(a, 16);
      p.send_word(b, 16);
      p.send_word(16'h5A5A, 16);
      pause(10);
      check("overrun", {15'h0, status.rx_overrun_flag}, 16'h0001);
      read_rx(a);
      pause(4);
      check("overrun clr", {15'h0, status.rx_overrun_flag}, 16'h0000);
      read_rx(b);
      pause(20);
      check("lost word", {15'h0, rx_word.valid}, 16'h0000);
      p.send_word(16'h00FF, 8);
      p.send_word(b, 16);
      read_rx(b);
      check("rx sync", {15'h0, status.rx_sync_error_flag}, 16'h0001);
      @(posedge sys_clk) clr_rx <= 1'b1;
      @(posedge sys_clk) clr_rx <= 1'b0;
      // Fill the transmit path until refused, with no frame syncs draining it
      @(posedge sys_clk) tx_word <= '{1'b1, 16'($urandom)};
      for (n = 0; n < 40; n++)
      begin
         #1 ok = tx_ready;
         @(posedge sys_clk);
         if (!ok)
            break;
         txq.push_back(tx_word.data);
         tx_word <= '{1'b1, 16'($urandom)};
      end
      tx_word <= '0;
      pause(2);
      check("rx sync clr", {15'h0, status.rx_sync_error_flag}, 16'h0000);
      check("refused", {15'h0, tx_ready}, 16'h0000);
      while (txq.size() > 0)
      begin
         w = txq.pop_front();
         p.take_word(16, got);
         check("tx word", got, w);
      end
      p.take_word(16, got);
      check("resend", got, w);
      pause(8);
      check("empty", {15'h0, status.tx_empty_n_flag}, 16'h0000);
      a = 16'($urandom);
      @(posedge sys_clk) tx_word <= '{1'b1, a};
      @(posedge sys_clk) tx_word <= '0;
      pause(8);
      check("empty set", {15'h0, status.tx_empty_n_flag}, 16'h0001);
      p.take_word(8, got);
      p.take_word(16, got);
      check("restart", got, a);
      pause(8);
      check("tx sync", {15'h0, status.tx_sync_error_flag}, 16'h0001);
      @(posedge sys_clk) clr_tx <= 1'b1;
      @(posedge sys_clk) clr_tx <= 1'b0;
      pause(2);
      check("tx sync clr", {15'h0, status.tx_sync_error_flag}, 16'h0000);
      end_of_test();
   end
endmodule : test_buffered_serial_port_error_flags
